// ---- common/mtpcs_pkg.sv ----
// Shared constants, modes and carriers of the timer set.
// Assumes one clock domain; configuration comes from a host block.
package mtpcs_pkg;

  // ==========================================================
  // Sizes
  localparam int NTIM = 8;
  localparam int NCH = 4;
  localparam int NPAIR = 6;
  localparam int NENC = 2;
  localparam int CNT_W = 32;
  localparam int PSC_W = 16;
  localparam int DT_W = 8;
  localparam int SRC_W = 3;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic [PSC_W-1:0] PSC_RST = 16'h0000;
  localparam logic [DT_W-1:0] DT_ZERO = 8'h00;

  // ==========================================================
  // Timer indices
  localparam int T_ADV = 0;
  localparam int T_WIDE = 1;
  localparam int T_QUAD = 2;
  localparam int T_SINGLE = 3;
  localparam int T_DUAL = 4;
  localparam int T_CMPA = 5;
  localparam int T_CMPB = 6;
  localparam int T_BAS = 7;

  // Per-timer shape: counter width, channels, up only, DMA
  localparam int TIM_W [NTIM] = '{16, 32, 16, 16, 16, 16, 16, 16};
  localparam int TIM_NC [NTIM] = '{4, 4, 4, 1, 2, 1, 1, 0};
  localparam bit TIM_UP [NTIM] = '{0, 0, 0, 1, 1, 1, 1, 1};
  localparam bit TIM_DMA [NTIM] = '{1, 1, 1, 0, 1, 1, 1, 1};

  // Complementary pairs: owning timer and channel
  localparam int PAIR_TIM [NPAIR] = '{0, 0, 0, 4, 5, 6};
  localparam int PAIR_CH [NPAIR] = '{0, 1, 2, 0, 0, 0};

  // Encoder and hall inputs serve these timers
  localparam int ENC_TIM [NENC] = '{1, 2};

  // Trigger link: bit s of row t set when timer s may drive t
  localparam logic [NTIM-1:0][NTIM-1:0] LINK_OK = {
    8'h00, 8'h30, 8'h50, 8'h61, 8'h00, 8'h03, 8'h05, 8'h16};

  // ==========================================================
  // Modes
  typedef enum logic [1:0] {
    CM_UP = 2'b00,
    CM_DOWN = 2'b01,
    CM_CENTER = 2'b11
  } mtpcs_cmode_e;

  typedef enum logic [2:0] {
    CH_FROZEN = 3'b000,
    CH_TOGGLE = 3'b001,
    CH_PWM1 = 3'b011,
    CH_PWM2 = 3'b010,
    CH_CAPTURE = 3'b110
  } mtpcs_chmode_e;

  typedef enum logic [1:0] {
    SL_NONE = 2'b00,
    SL_RESET = 2'b01,
    SL_START = 2'b11
  } mtpcs_slave_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic en;
    mtpcs_cmode_e cmode;
    logic opm;
    logic [PSC_W-1:0] psc;
    logic [CNT_W-1:0] arr;
    mtpcs_slave_e slave;
    logic [SRC_W-1:0] trig_src;
    logic enc_en;
    logic hall_en;
    logic dbg_freeze;
    logic dma_en;
    mtpcs_chmode_e [NCH-1:0] chmode;
    logic [NCH-1:0] cap_fall;
  } mtpcs_cfg_s;

  typedef logic [NCH-1:0][CNT_W-1:0] mtpcs_ccr_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic upd;
    logic down;
    logic stopped;
  } mtpcs_stat_s;

endpackage

// ---- hdl/mtpcs_timer_core.sv ----
// One auto-reload timer: prescaler, counter, up to four channels.
// Assumes synchronous inputs; step and trigger come from the set.
`timescale 1ns/1ps
module mtpcs_timer_core
  import mtpcs_pkg::*;
#(
  parameter int W = 16,
  parameter int NC = NCH,
  parameter bit UP_ONLY = 1'b0,
  parameter bit HAS_DMA = 1'b1
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Configuration and compare values
  input wire mtpcs_cfg_s cfg_i,
  input wire mtpcs_ccr_t ccr_i,
  // Event inputs
  input wire logic [NCH-1:0] cap_i,
  input wire logic step_i,
  input wire logic step_down_i,
  input wire logic trig_i,
  input wire logic halt_i,
  // Results
  output mtpcs_stat_s stat_o,
  output logic [NCH-1:0] ref_o,
  output mtpcs_ccr_t capv_o,
  output logic [NCH-1:0] capf_o,
  output logic dma_o
);

  // ==========================================================
  // State
  localparam logic [CNT_W-1:0] MASK = CNT_W'({W{1'b1}});

  typedef struct packed {
    logic [PSC_W-1:0] psc_cnt;
    logic [CNT_W-1:0] cnt;
    logic down;
    logic done;
    logic upd;
    logic [NCH-1:0] oc;
    logic [NCH-1:0] cap_q;
    logic [NCH-1:0] capf;
    mtpcs_ccr_t capv;
    logic dma;
  } mtpcs_core_st_s;

  mtpcs_core_st_s s_reg;
  mtpcs_core_st_s s_next;
  logic [CNT_W-1:0] top;
  logic center;
  logic frz;
  logic run;
  logic dn;
  logic psc_hit;
  logic cnt_tick;
  logic trig_rst;
  logic [NCH-1:0] edge_hit;

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    edge_hit = '0;
    s_next.upd = 1'b0;
    s_next.capf = '0;
    top = cfg_i.arr & MASK;
    center = !UP_ONLY && cfg_i.cmode == CM_CENTER && !cfg_i.enc_en;
    // [R17] Debug freeze
    frz = halt_i && cfg_i.dbg_freeze;
    run = cfg_i.en && !s_reg.done && !frz;
    // [R1] Direction select
    // Encoder direction follows the last step, not the idle lines
    dn = center ? s_reg.down : (!UP_ONLY && (cfg_i.enc_en ?
         (step_i ? step_down_i : s_reg.down) : cfg_i.cmode == CM_DOWN));
    s_next.down = dn;
    // [R2] Divide by psc plus one
    psc_hit = s_reg.psc_cnt == cfg_i.psc;
    cnt_tick = run && (cfg_i.enc_en ? step_i : psc_hit);
    if (run && !cfg_i.enc_en) begin
      s_next.psc_cnt = psc_hit ? PSC_RST : s_reg.psc_cnt + 1'b1;
    end
    // [R19] Reload and update
    if (cnt_tick) begin
      if (!dn) begin
        if (s_reg.cnt >= top) begin
          s_next.upd = 1'b1;
          if (center && top != CNT_RST) begin
            s_next.down = 1'b1;
            s_next.cnt = top - 1'b1;
          end else begin
            s_next.cnt = CNT_RST;
          end
        end else begin
          s_next.cnt = s_reg.cnt + 1'b1;
        end
      end else if (s_reg.cnt == CNT_RST) begin
        s_next.upd = 1'b1;
        if (center) begin
          s_next.down = 1'b0;
          s_next.cnt = CNT_W'(top != CNT_RST);
        end else begin
          s_next.cnt = top;
        end
      end else begin
        s_next.cnt = s_reg.cnt - 1'b1;
      end
    end
    // Slave reset restarts the period and counts as an update
    trig_rst = trig_i && cfg_i.slave == SL_RESET;
    if (trig_rst) begin
      s_next.cnt = dn ? top : CNT_RST;
      s_next.psc_cnt = PSC_RST;
      s_next.upd = 1'b1;
    end
    // [R5] One-pulse stop
    if (s_next.upd && cfg_i.opm) begin
      s_next.done = 1'b1;
    end
    if ((trig_i && cfg_i.slave == SL_START) || !cfg_i.en) begin
      s_next.done = 1'b0;
    end
    // [R20] Capture and compare
    for (int c = 0; c < NC; c++) begin
      s_next.cap_q[c] = cap_i[c];
      edge_hit[c] = (cap_i[c] ^ s_reg.cap_q[c]) &&
                    (cap_i[c] ^ cfg_i.cap_fall[c]);
      unique case (cfg_i.chmode[c])
        CH_CAPTURE: begin
          if (edge_hit[c]) begin
            s_next.capv[c] = s_reg.cnt;
            s_next.capf[c] = 1'b1;
          end
        end
        CH_TOGGLE: begin
          if (cnt_tick && s_next.cnt == ccr_i[c]) begin
            s_next.oc[c] = !s_reg.oc[c];
          end
        end
        // [R6] Full duty range
        CH_PWM1: s_next.oc[c] = s_next.cnt < ccr_i[c];
        CH_PWM2: s_next.oc[c] = s_next.cnt >= ccr_i[c];
        CH_FROZEN: s_next.oc[c] = s_reg.oc[c];
        default: s_next.oc[c] = s_reg.oc[c];
      endcase
    end
    // [R11] Own DMA request
    s_next.dma = HAS_DMA && cfg_i.dma_en &&
                 (s_next.upd || (|s_next.capf));
  end

  // State register, frozen while the enable is low
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign stat_o = '{cnt: s_reg.cnt, upd: s_reg.upd,
                    down: s_reg.down, stopped: s_reg.done};
  assign ref_o = s_reg.oc;
  assign capv_o = s_reg.capv;
  assign capf_o = s_reg.capf;
  assign dma_o = s_reg.dma;

  // ==========================================================
  // Checks
  AST_WRAP_UP: assert property ( // [R19]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && cnt_tick && !dn && !center && !trig_rst &&
    s_reg.cnt >= top |=> s_reg.cnt == CNT_RST && s_reg.upd)
    else $error("counter did not wrap to zero at top");

  AST_WRAP_DN: assert property ( // [R19]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && cnt_tick && dn && !center && !trig_rst &&
    s_reg.cnt == CNT_RST |=> s_reg.cnt == $past(top) && s_reg.upd)
    else $error("down counter did not reload at zero");

  AST_PSC_HOLD: assert property ( // [R2]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && !cfg_i.enc_en && !psc_hit && !trig_rst
    |=> $stable(s_reg.cnt))
    else $error("counter moved between prescaler ticks");

  AST_FREEZE: assert property ( // [R17]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && frz && !trig_rst |=> $stable(s_reg.cnt))
    else $error("counter moved while frozen");

  AST_OPM_STOP: assert property ( // [R5]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && cfg_i.en && cfg_i.opm && cnt_tick && !dn && !center &&
    s_reg.cnt >= top && cfg_i.slave != SL_RESET && !trig_i
    |=> s_reg.done)
    else $error("one-pulse counter kept running");

  AST_UP_ONLY: assert property ( // [R14]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    UP_ONLY |-> !s_reg.down)
    else $error("upcounting timer counted down");

  if (NC > 0) begin : g_ch_ast
    AST_CAPTURE: assert property ( // [R20]
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      ce_i && cfg_i.chmode[0] == CH_CAPTURE && edge_hit[0]
      |=> s_reg.capv[0] == $past(s_reg.cnt) && s_reg.capf[0])
      else $error("capture missed the counter value");

    AST_PWM_FULL: assert property ( // [R6]
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      ce_i && cfg_i.chmode[0] == CH_PWM1 && ccr_i[0] > top &&
      s_reg.cnt <= top |=> s_reg.oc[0])
      else $error("full duty output went low");

    AST_PWM_OFF: assert property ( // [R6]
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      ce_i && cfg_i.chmode[0] == CH_PWM1 && ccr_i[0] == CNT_RST
      |=> !s_reg.oc[0])
      else $error("zero duty output went high");
  end

endmodule

// ---- hdl/mtpcs_timer_set.sv ----
// Timer set: eight timers, trigger link, encoder and hall front
// ends, dead-time pairs and the DAC trigger.
// Contract
// [R1] Advanced timer: 16-bit up/down/center counter, DMA, four channels, three complementary.
// [R2] Every prescaler divides by any integer from one to 65536.
// [R3] Advanced timer drives three complementary pairs, six outputs, as three-phase PWM.
// [R4] Complementary pairs insert programmable dead time between off and on.
// [R5] Channels offer capture, compare, edge or center PWM, one-pulse mode.
// [R6] PWM duty reaches every value from fully off to fully on.
// [R7] Wide timer: 32-bit up/down/center counter with 16-bit prescaler.
// [R8] Quad-channel timer: 16-bit up/down counter with 16-bit prescaler.
// [R9] Wide and quad timers each have four independent channels.
// [R10] Wide and quad timers decode quadrature encoders and one to three halls.
// [R11] Wide and quad timers raise their own DMA requests independently.
// [R12] Advanced, wide and quad timers synchronise over the trigger link.
// [R13] Single-channel timer: 16-bit upcounter, one channel, no DMA.
// [R14] Dual timer has two channels, complementary singles one; all count up.
// [R15] Dual and complementary singles: one dead-time complementary output, own DMA.
// [R16] Dual timer links with both complementary singles and the advanced timer.
// [R17] Each counter can stop while the processor is halted for debug.
// [R18] Basic timer is a 16-bit up time base triggering the DAC.
// [R19] Counter reloads at top or zero and raises an update event.
// [R20] Capture latches the counter on an edge; compare acts on equality.
// Assumes configuration inputs come from a host register block.
`timescale 1ns/1ps
module mtpcs_timer_set
  import mtpcs_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Configuration, compare values, dead times, debug halt
  input wire mtpcs_cfg_s [NTIM-1:0] cfg_i,
  input wire mtpcs_ccr_t [NTIM-1:0] ccr_i,
  input wire logic [NPAIR-1:0][DT_W-1:0] dead_i,
  input wire logic dbg_halt_i,
  // Capture pins, encoder and hall inputs
  input wire logic [NTIM-1:0][NCH-1:0] cap_i,
  input wire logic [NENC-1:0] enc_a_i,
  input wire logic [NENC-1:0] enc_b_i,
  input wire logic [NENC-1:0][2:0] hall_i,
  // Timer results
  output mtpcs_stat_s [NTIM-1:0] stat_o,
  output logic [NTIM-1:0][NCH-1:0] oc_o,
  output mtpcs_ccr_t [NTIM-1:0] capv_o,
  output logic [NTIM-1:0][NCH-1:0] capf_o,
  output logic [NTIM-1:0] dma_o,
  // Complementary outputs and DAC trigger
  output logic [NPAIR-1:0] pwm_p_o,
  output logic [NPAIR-1:0] pwm_n_o,
  output logic dac_trig_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [NENC-1:0] enc_a_q;
    logic [NENC-1:0] enc_b_q;
    logic [NENC-1:0] hall_q;
    logic [NPAIR-1:0] dt_ref;
    logic [NPAIR-1:0][DT_W-1:0] dt_cnt;
    logic [NPAIR-1:0] pwm_p;
    logic [NPAIR-1:0] pwm_n;
    logic dac_trig;
  } mtpcs_set_st_s;

  mtpcs_set_st_s m_reg;
  mtpcs_set_st_s m_next;
  logic [NTIM-1:0] upd;
  logic [NTIM-1:0] trig;
  logic [NTIM-1:0] step;
  logic [NTIM-1:0] step_down;
  logic [NTIM-1:0][NCH-1:0] cap_eff;
  logic [NENC-1:0] hall_chg;
  logic ref_bit;

  // ==========================================================
  // Front ends and link
  always_comb begin
    step = '0;
    step_down = '0;
    cap_eff = cap_i;
    hall_chg = '0;
    // [R12] Masked trigger link
    for (int t = 0; t < NTIM; t++) begin
      trig[t] = cfg_i[t].slave != SL_NONE &&
                LINK_OK[t][cfg_i[t].trig_src] &&
                upd[cfg_i[t].trig_src];
    end
    for (int e = 0; e < NENC; e++) begin
      // [R10] Quadrature x4 decode
      step[ENC_TIM[e]] = (enc_a_i[e] ^ m_reg.enc_a_q[e]) ^
                         (enc_b_i[e] ^ m_reg.enc_b_q[e]);
      step_down[ENC_TIM[e]] = !(enc_a_i[e] ^ m_reg.enc_b_q[e]);
      // [R10] Hall change capture
      hall_chg[e] = (^hall_i[e]) ^ m_reg.hall_q[e];
      if (cfg_i[ENC_TIM[e]].hall_en) begin
        cap_eff[ENC_TIM[e]][0] = hall_chg[e];
      end
    end
  end

  // ==========================================================
  // Timers
  // [R1] [R7] [R8] [R9] [R13] Per-timer shapes
  // [R14] [R15] Counting direction, DMA
  for (genvar t = 0; t < NTIM; t++) begin : g_tim
    mtpcs_timer_core #(
      .W(TIM_W[t]),
      .NC(TIM_NC[t]),
      .UP_ONLY(TIM_UP[t]),
      .HAS_DMA(TIM_DMA[t])
    ) u_core (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .cfg_i(cfg_i[t]),
      .ccr_i(ccr_i[t]),
      .cap_i(cap_eff[t]),
      .step_i(step[t]),
      .step_down_i(step_down[t]),
      .trig_i(trig[t]),
      .halt_i(dbg_halt_i),
      .stat_o(stat_o[t]),
      .ref_o(oc_o[t]),
      .capv_o(capv_o[t]),
      .capf_o(capf_o[t]),
      .dma_o(dma_o[t])
    );
    assign upd[t] = stat_o[t].upd;

    // [R16] Link mask check
    AST_LINK_MASK: assert property ( // [R12]
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !LINK_OK[t][cfg_i[t].trig_src] |-> !trig[t])
      else $error("trigger passed a forbidden link");
  end

  // ==========================================================
  // Dead time, encoder history, DAC trigger
  always_comb begin
    m_next = m_reg;
    ref_bit = 1'b0;
    m_next.enc_a_q = enc_a_i;
    m_next.enc_b_q = enc_b_i;
    for (int e = 0; e < NENC; e++) begin
      m_next.hall_q[e] = ^hall_i[e];
    end
    // [R3] [R4] Pairs with dead time
    for (int p = 0; p < NPAIR; p++) begin
      ref_bit = oc_o[PAIR_TIM[p]][PAIR_CH[p]];
      if (ref_bit != m_reg.dt_ref[p]) begin
        // Both sides off first unless the dead time is zero, so the bridge never shoots through
        m_next.dt_ref[p] = ref_bit;
        m_next.dt_cnt[p] = dead_i[p];
        m_next.pwm_p[p] = ref_bit && dead_i[p] == DT_ZERO;
        m_next.pwm_n[p] = !ref_bit && dead_i[p] == DT_ZERO;
      end else if (m_reg.dt_cnt[p] != DT_ZERO) begin
        m_next.dt_cnt[p] = m_reg.dt_cnt[p] - 1'b1;
      end else begin
        m_next.pwm_p[p] = m_reg.dt_ref[p];
        m_next.pwm_n[p] = !m_reg.dt_ref[p];
      end
    end
    // [R18] DAC trigger pulse
    m_next.dac_trig = upd[T_BAS];
  end

  // State register, frozen while the enable is low
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      m_reg <= '0;
    end else if (ce_i) begin
      m_reg <= m_next;
    end
  end

  assign pwm_p_o = m_reg.pwm_p;
  assign pwm_n_o = m_reg.pwm_n;
  assign dac_trig_o = m_reg.dac_trig;

  // ==========================================================
  // Checks
  for (genvar p = 0; p < NPAIR; p++) begin : g_pair_ast
    AST_DT_EXCL: assert property ( // [R4]
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !(pwm_p_o[p] && pwm_n_o[p]))
      else $error("both sides of a pair are on");

    AST_DT_GAP: assert property ( // [R4]
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      ce_i && $fell(pwm_p_o[p]) && dead_i[p] != DT_ZERO
      |=> !pwm_n_o[p])
      else $error("low side turned on without dead time");
  end

  AST_DAC_TRIG: assert property ( // [R18]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && upd[T_BAS] |=> dac_trig_o)
    else $error("basic timer update gave no DAC trigger");

  AST_ENC_STEP: assert property ( // [R10]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && cfg_i[T_WIDE].enc_en && cfg_i[T_WIDE].en &&
    !stat_o[T_WIDE].stopped && !dbg_halt_i &&
    cfg_i[T_WIDE].slave == SL_NONE &&
    cfg_i[T_WIDE].arr != CNT_RST && step[T_WIDE]
    |=> stat_o[T_WIDE].cnt != $past(stat_o[T_WIDE].cnt))
    else $error("encoder step did not move the counter");

endmodule

// ---- verif/mtpcs_field_model.sv ----
// Field-side model: one quadrature encoder and a three-wire hall
// sensor, shared by both encoder-capable timers.
// Assumes the bench asks for at most one step per clock.
`timescale 1ns/1ps
module mtpcs_field_model
  import mtpcs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Step requests from the bench
  input wire logic fwd_i,
  input wire logic rev_i,
  // Sensor lines
  output logic [NENC-1:0] enc_a_o,
  output logic [NENC-1:0] enc_b_o,
  output logic [NENC-1:0][2:0] hall_o
);
  // Six hall states; exactly one wire changes per step
  localparam logic [5:0][2:0] HALL_SEQ = {
    3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  logic [2:0] pos_reg;
  logic [1:0] ph_reg;

  // ==========================================================
  // Position
  // A forward step moves phase and hall state on by one
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pos_reg <= 3'h0;
      ph_reg <= 2'h0;
    end else if (fwd_i) begin
      pos_reg <= (pos_reg == 3'h5) ? 3'h0 : pos_reg + 3'h1;
      ph_reg <= ph_reg + 2'h1;
    end else if (rev_i) begin
      pos_reg <= (pos_reg == 3'h0) ? 3'h5 : pos_reg - 3'h1;
      ph_reg <= ph_reg - 2'h1;
    end
  end

  // Gray phase: going forward, A rises a quarter cycle before B
  assign enc_a_o = {NENC{ph_reg == 2'h1 || ph_reg == 2'h2}};
  assign enc_b_o = {NENC{ph_reg[1]}};
  assign hall_o = {NENC{HALL_SEQ[pos_reg]}};
endmodule

// ---- verif/tb_multi_timer_pwm_capture_set.sv ----
// Bench for the timer set: counting modes, duty, dead time, capture,
// hall, encoder, debug freeze and DAC trigger.
// Assumes the field model drives the encoder and hall lines.
`timescale 1ns/1ps
module tb_multi_timer_pwm_capture_set;
  import mtpcs_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m;} mtpcs_note_s;

  // ==========================================================
  // Signals
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  mtpcs_cfg_s [NTIM-1:0] cfg = '0;
  mtpcs_ccr_t [NTIM-1:0] ccr = '0;
  logic [NPAIR-1:0][DT_W-1:0] dead = '0;
  logic halt = 1'b0;
  logic [NTIM-1:0][NCH-1:0] cap = '0;
  logic fwd = 1'b0;
  logic rev = 1'b0;
  logic [NENC-1:0] enc_a;
  logic [NENC-1:0] enc_b;
  logic [NENC-1:0][2:0] hall;
  mtpcs_stat_s [NTIM-1:0] stat;
  logic [NTIM-1:0][NCH-1:0] oc;
  logic [NTIM-1:0][NCH-1:0] capf;
  mtpcs_ccr_t [NTIM-1:0] capv;
  logic [NTIM-1:0] dma;
  logic [NPAIR-1:0] pwm_p;
  logic [NPAIR-1:0] pwm_n;
  logic dac;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int tsel = 0;
  int run = 0;
  int hi = 0;
  int lu [NTIM] = '{default: 0};
  logic [31:0] seed = 32'h0000_fc02;
  mtpcs_note_s qu[$];
  mtpcs_note_s qd[$];
  mtpcs_note_s qc[$];
  mtpcs_note_s qa[$];

  // Clock at 125 MHz
  always #4 sys_clk_i = ~sys_clk_i;

  mtpcs_timer_set dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(1'b1), .cfg_i(cfg), .ccr_i(ccr), .dead_i(dead),
    .dbg_halt_i(halt), .cap_i(cap), .enc_a_i(enc_a), .enc_b_i(enc_b),
    .hall_i(hall), .stat_o(stat), .oc_o(oc), .capv_o(capv),
    .capf_o(capf), .dma_o(dma), .pwm_p_o(pwm_p), .pwm_n_o(pwm_n),
    .dac_trig_o(dac));

  mtpcs_field_model field_u (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .fwd_i(fwd), .rev_i(rev), .enc_a_o(enc_a),
    .enc_b_o(enc_b), .hall_o(hall));

  // ==========================================================
  // Shared tasks
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic note(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  // Oldest note is taken only when a result shows up
  task automatic chk(ref mtpcs_note_s q[$], input string nm,
                     input logic [31:0] g);
    mtpcs_note_s e;
    if (q.size() > 0) begin
      e = q.pop_front();
      note(nm, e.v & e.m, g & e.m);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // Bounded wait for an update; the pulse seen is never scored
  task automatic wait_upd(int t);
    int i;
    for (i = 0; i < 5000; i++) begin
      @(posedge sys_clk_i);
      #1;
      if (stat[t].upd === 1'b1) break;
    end
    if (i == 5000) begin
      bad_count++;
      wrap_up();
    end
    @(posedge sys_clk_i);
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 5000; i++) begin
      if (qu.size() + qd.size() + qc.size() + qa.size() == 0) break;
      @(posedge sys_clk_i);
    end
    if (i == 5000) begin
      bad_count++;
      wrap_up();
    end
  endtask

  // Mid-run reset also clears every counter to a known start
  task automatic restart();
    cfg <= '0;
    sys_rst_i <= 1'b1;
    tick(2);
    sys_rst_i <= 1'b0;
    tick(1);
  endtask

  // ==========================================================
  // Monitor: sampled at the falling edge, where outputs are settled
  always @(posedge sys_clk_i) cyc <= cyc + 1;
  always @(negedge sys_clk_i) begin
    if (sys_rst_i) begin
      run = 0;
    end else begin
      if (stat[tsel].upd) begin
        chk(qu, "update", {stat[tsel].cnt[7:0], 12'(hi),
            12'(cyc - lu[tsel])});
        hi = 0;
      end
      if (oc[tsel][0]) hi = hi + 1;
      if (capf[tsel][0]) chk(qc, "capture", capv[tsel][0]);
      if (dac) chk(qa, "dac_trigger", 32'(cyc - lu[T_BAS]));
      note("pair_overlap", 32'h0, {31'h0, pwm_p[0] & pwm_n[0]});
      note("single_dma", 32'h0, {31'h0, dma[T_SINGLE]});
      if (!pwm_p[0] && !pwm_n[0]) begin
        run = run + 1;
      end else begin
        if (run > 0) chk(qd, "dead_gap", 32'(run));
        run = 0;
      end
      for (int t = 0; t < NTIM; t++) begin
        if (stat[t].upd) lu[t] = cyc;
      end
    end
  end

  // ==========================================================
  // Stimulus
  initial begin
    mtpcs_cfg_s k;
    mtpcs_cfg_s k2;
    logic [31:0] r;
    int p, a, c, d, kk;
    mtpcs_cmode_e md [3] = '{CM_UP, CM_DOWN, CM_CENTER};
    tick(10);
    sys_rst_i <= 1'b0;
    // Counting modes, prescale, reload and duty from 0 to 100 %
    for (int t = 0; t < 4; t++) begin
      for (int m = 0; m < 3; m++) begin
        if (TIM_UP[t] && m > 0) continue;
        restart();
        r = rnd();
        p = int'(r[1:0]);
        a = 2 + int'(r[4:2]);
        c = (t == 0) ? (m == 0 ? 0 : a + 1) : int'(r[7:4]) % (a + 3);
        k = '0;
        k.en = 1'b1;
        k.cmode = md[m];
        k.psc = 16'(p);
        k.arr = 32'(a);
        k.dma_en = 1'b1;
        k.chmode[0] = CH_PWM1;
        cfg[t] <= k;
        ccr[t][0] <= 32'(c);
        tsel = t;
        wait_upd(t);
        d = (c > a + 1) ? a + 1 : c;
        kk = (m == 2) ? a : a + 1;
        repeat (3) qu.push_back('{{8'(m == 1 ? a : 0), 12'(d * (p + 1)),
          12'(kk * (p + 1))}, (m == 2) ? 32'h0000_0fff : '1});
        drain();
      end
    end
    // Debug halt stretches the period only when freezing is chosen
    restart();
    k = '0;
    k.en = 1'b1;
    k.psc = 16'h0001;
    k.arr = 32'h7;
    tsel = T_QUAD;
    for (int f = 1; f >= 0; f--) begin
      k.dbg_freeze = f[0];
      cfg[T_QUAD] <= k;
      wait_upd(T_QUAD);
      qu.push_back('{32'(16 + 5 * f), 32'h0000_0fff});
      tick(2);
      halt <= 1'b1;
      tick(5);
      halt <= 1'b0;
      drain();
    end
    // Dead time on the first complementary pair
    for (int i = 0; i < 2; i++) begin
      restart();
      d = 1 + int'(rnd() % 6);
      dead[0] <= 8'(d);
      k = '0;
      k.en = 1'b1;
      // Both phases outlast the longest gap, so gaps never merge
      k.arr = 32'h13;
      k.chmode[0] = CH_PWM1;
      cfg[T_ADV] <= k;
      ccr[T_ADV][0] <= 32'ha;
      tsel = T_ADV;
      wait_upd(T_ADV);
      repeat (4) qd.push_back('{32'(d + 1), '1});
      drain();
    end
    // Capture on a rising, then on a falling pin edge
    restart();
    k = '0;
    k.en = 1'b1;
    k.arr = 32'h9;
    k.chmode[0] = CH_CAPTURE;
    tsel = T_QUAD;
    for (int f = 0; f < 2; f++) begin
      k.cap_fall[0] = f[0];
      cfg[T_QUAD] <= k;
      cap[T_QUAD][0] <= f[0];
      wait_upd(T_QUAD);
      tick(int'(rnd() % 7));
      cap[T_QUAD][0] <= ~f[0];
      #1;
      kk = cyc;
      qc.push_back('{32'((kk - lu[T_QUAD]) % 10), '1});
      tick(3);
      drain();
    end
    cap[T_QUAD][0] <= 1'b0;
    // Hall changes capture on the quad timer; encoder drives the wide
    restart();
    k.hall_en = 1'b1;
    k.cap_fall[0] = 1'b0;
    cfg[T_QUAD] <= k;
    k2 = '0;
    k2.en = 1'b1;
    k2.enc_en = 1'b1;
    k2.arr = 32'h3e8;
    cfg[T_WIDE] <= k2;
    wait_upd(T_QUAD);
    // Hall moves one cycle after the step; capture takes that count
    for (int i = 0; i < 8; i++) begin
      fwd <= (i < 4);
      rev <= (i >= 4);
      tick(1);
      fwd <= 1'b0;
      rev <= 1'b0;
      @(negedge sys_clk_i);
      kk = cyc;
      qc.push_back('{32'((kk - lu[T_QUAD]) % 10), '1});
      tick(4);
      @(negedge sys_clk_i);
      if (i == 3 || i == 7)
        note("enc_down", 32'(i == 7), {31'h0, stat[T_WIDE].down});
      @(posedge sys_clk_i);
    end
    drain();
    // One-pulse stop, then a restart from the advanced timer's update
    restart();
    k = '0;
    k.en = 1'b1;
    k.opm = 1'b1;
    k.arr = 32'h3;
    k.slave = SL_START;
    k.trig_src = 3'(T_ADV);
    cfg[T_QUAD] <= k;
    wait_upd(T_QUAD);
    tick(2);
    @(negedge sys_clk_i);
    note("opm_stopped", 32'h1, {31'h0, stat[T_QUAD].stopped});
    @(posedge sys_clk_i);
    k2 = '0;
    k2.en = 1'b1;
    k2.arr = 32'h9;
    cfg[T_ADV] <= k2;
    wait_upd(T_ADV);
    @(negedge sys_clk_i);
    note("link_start", 32'h0, {31'h0, stat[T_QUAD].stopped});
    // Basic timer update triggers the DAC one cycle later
    restart();
    k = '0;
    k.en = 1'b1;
    k.arr = 32'h4;
    cfg[T_BAS] <= k;
    wait_upd(T_BAS);
    repeat (3) qa.push_back('{32'h1, '1});
    drain();
    wrap_up();
  end
endmodule
